/* logic/rxgfc_map.svh */
// Operation
// - six-bit word sets gain -12 to +48 dB
// - alternative three-bit mapping, 8 dB steps
// - two coarse stages span -12..+42 dB, 6 dB
// - fine stage adds 0..6 dB in 1 dB
// - look-up table splits gain across stages
// - offset calibration at power-up or on request
// - calibration shorts input, forces high gain
// - servo trims DAC until offset within 32
// - target write starts filter calibration, under 100us
// - filter enabled at reset, clearing bit 0 bypasses
// - eight-bit cut-off target at address 0x08
// - rewriting same target still recalibrates
`ifndef RXGFC_MAP_SVH
`define RXGFC_MAP_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define RXGFC_ADDR_FCTRL     8'h07
`define RXGFC_ADDR_FTARGET   8'h08
`define RXGFC_FCTRL_RST      8'h01
`define RXGFC_FTARGET_RST    8'h80
`define RXGFC_FCTRL_EN_BIT   0

// ----------------------------------------
// gain mapping
// ----------------------------------------
`define RXGFC_GAIN_MAX       6'h3c
`define RXGFC_GAIN3_MAX      3'h6
`define RXGFC_GAIN3_SHIFT    3
`define RXGFC_COARSE_STEP    6
`define RXGFC_COARSE_MAX     9
`define RXGFC_STG1_MAX       4
`define RXGFC_FINE_MAX       3'h6
`define RXGFC_LUT_DEPTH      61

// ----------------------------------------
// calibration timing
// ----------------------------------------
`define RXGFC_OFS_LIMIT      12'sh020
`define RXGFC_CALDAC_MID     8'h80
`define RXGFC_OC_SETTLE      8'h10
`define RXGFC_CLK_PERIOD_NS  50
`define RXGFC_FCAL_TIME_NS   100000
`define RXGFC_FCAL_CYCLES    ((`RXGFC_FCAL_TIME_NS / `RXGFC_CLK_PERIOD_NS) - 1)

`endif

/* logic/rxgfc_pkg.sv */
`include "rxgfc_map.svh"

package rxgfc_pkg;

	typedef logic [2:0] rxgfc_stage_t;
	typedef logic [5:0] rxgfc_gidx_t;

	typedef enum logic [2:0] {
		OC_IDLE   = 3'h1,
		OC_SETTLE = 3'h2,
		OC_CHECK  = 3'h4
	} rxgfc_oc_state_t;

	// total gain above -12 dB, in 1 dB steps
	function automatic rxgfc_gidx_t rxgfc_gain_index(input logic [5:0] word, input logic mode3);
		rxgfc_gidx_t idx;
		logic [2:0]  c3;
		idx = 6'h00;
		c3  = (word[2:0] > `RXGFC_GAIN3_MAX) ? `RXGFC_GAIN3_MAX : word[2:0];
		if (mode3) begin
			idx = {c3, 3'h0};
		end else begin
			idx = (word > `RXGFC_GAIN_MAX) ? `RXGFC_GAIN_MAX : word;
		end
		return idx;
	endfunction : rxgfc_gain_index

endpackage : rxgfc_pkg

/* logic/rxgfc_gain_lut.sv */
`timescale 1ns/1ns
`include "rxgfc_map.svh"

module rxgfc_gain_lut
	import rxgfc_pkg::*;
(
	// requested gain
	input  wire logic [5:0]   gainWord,
	input  wire logic         gainMode3,
	// per-stage settings
	output rxgfc_stage_t      coarse1,
	output rxgfc_stage_t      coarse2,
	output rxgfc_stage_t      fine
);

	// ----------------------------------------
	// constant table {coarse1, coarse2, fine}
	// ----------------------------------------
	logic [8:0]  lut [0:`RXGFC_LUT_DEPTH-1];
	rxgfc_gidx_t gainIdx;
	logic [8:0]  entry;

	genvar i;
	generate
		for (i = 0; i < `RXGFC_LUT_DEPTH; i++) begin : g_lut
			localparam int CT = (i / `RXGFC_COARSE_STEP > `RXGFC_COARSE_MAX) ?
				`RXGFC_COARSE_MAX : i / `RXGFC_COARSE_STEP;
			localparam int FT = i - `RXGFC_COARSE_STEP * CT;
			localparam int C1 = (CT > `RXGFC_STG1_MAX) ? `RXGFC_STG1_MAX : CT;
			localparam int C2 = CT - C1;
			// stage one takes coarse steps first, it carries the low-noise preamp
			assign lut[i] = {3'(C1), 3'(C2), 3'(FT)};
		end
	endgenerate

	assign gainIdx = rxgfc_gain_index(gainWord, gainMode3);
	assign entry   = lut[gainIdx];
	assign coarse1 = entry[8:6];
	assign coarse2 = entry[5:3];
	assign fine    = entry[2:0];

endmodule : rxgfc_gain_lut

/* logic/rxgfc_top.sv */
`timescale 1ns/1ns
`include "rxgfc_map.svh"

module rxgfc_top
	import rxgfc_pkg::*;
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	// serial-port register access
	input  wire logic         regWrEn,
	input  wire logic         regRdEn,
	input  wire logic [7:0]   regAddr,
	input  wire logic [7:0]   regWrData,
	output logic [7:0]        regRdData,
	// gain request pins and mode
	input  wire logic [5:0]   gainPins,
	input  wire logic         gainMode3,
	// offset calibration request and measurement
	input  wire logic         offsetCalReq,
	input  wire logic signed [11:0] offsetMeas,
	// amplifier stage settings
	output rxgfc_stage_t      coarseStage1,
	output rxgfc_stage_t      coarseStage2,
	output rxgfc_stage_t      fineStage,
	output logic              inputShort,
	// offset calibration status
	output logic [7:0]        calDacCode,
	output logic              offsetCalBusy,
	output logic              offsetCalFail,
	// filter control and status
	output logic              filterEnable,
	output logic [7:0]        cutoffApplied,
	output logic              filterCalBusy
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic [1:0] rstSync_reg;
	logic       rstnSys;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) rstSync_reg <= 2'h0;
		else rstSync_reg <= {rstSync_reg[0], 1'b1};
	end
	assign rstnSys = rstSync_reg[1];

	// ----------------------------------------
	// gain pins synchroniser and table
	// ----------------------------------------
	logic [5:0]   gainMeta_reg;
	logic [5:0]   gainSync_reg;
	logic         modeMeta_reg;
	logic         modeSync_reg;
	rxgfc_stage_t lutC1;
	rxgfc_stage_t lutC2;
	rxgfc_stage_t lutF;

	always_ff @(posedge clk_sys or negedge rstnSys) begin
		if (!rstnSys) begin
			gainMeta_reg <= 6'h00;
			gainSync_reg <= 6'h00;
			modeMeta_reg <= 1'b0;
			modeSync_reg <= 1'b0;
		end else begin
			gainMeta_reg <= gainPins;
			gainSync_reg <= gainMeta_reg;
			modeMeta_reg <= gainMode3;
			modeSync_reg <= modeMeta_reg;
		end
	end

	rxgfc_gain_lut u_lut (
		.gainWord  (gainSync_reg),
		.gainMode3 (modeSync_reg),
		.coarse1   (lutC1),
		.coarse2   (lutC2),
		.fine      (lutF)
	);

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	logic [7:0] fctrl_reg;
	logic [7:0] ftarget_reg;
	logic [7:0] rdData_reg;
	logic       ctrlWr;
	logic       tgtWr;
	logic [7:0] rdMux;

	assign ctrlWr = regWrEn && (regAddr == `RXGFC_ADDR_FCTRL);
	assign tgtWr  = regWrEn && (regAddr == `RXGFC_ADDR_FTARGET);
	assign rdMux  = (regAddr == `RXGFC_ADDR_FCTRL)   ? fctrl_reg :
	                (regAddr == `RXGFC_ADDR_FTARGET) ? ftarget_reg : 8'h00;

	always_ff @(posedge clk_sys or negedge rstnSys) begin
		if (!rstnSys) begin
			fctrl_reg   <= `RXGFC_FCTRL_RST;
			ftarget_reg <= `RXGFC_FTARGET_RST;
			rdData_reg  <= 8'h00;
		end else begin
			if (ctrlWr) fctrl_reg <= regWrData;
			if (tgtWr) ftarget_reg <= regWrData;
			if (regRdEn) rdData_reg <= rdMux;
		end
	end

	// ----------------------------------------
	// filter cut-off calibration
	// ----------------------------------------
	logic        fcalBusy_reg;
	logic [10:0] fcalCnt_reg;
	logic [7:0]  fcalValue_reg;
	logic [7:0]  applied_reg;
	logic        fcalLast;

	assign fcalLast = (fcalCnt_reg == 11'(`RXGFC_FCAL_CYCLES - 1));

	// any write restarts, even the same value: drift recalibration relies on it
	always_ff @(posedge clk_sys or negedge rstnSys) begin
		if (!rstnSys) begin
			fcalBusy_reg  <= 1'b0;
			fcalCnt_reg   <= 11'h000;
			fcalValue_reg <= `RXGFC_FTARGET_RST;
			applied_reg   <= `RXGFC_FTARGET_RST;
		end else if (tgtWr) begin
			fcalBusy_reg  <= 1'b1;
			fcalCnt_reg   <= 11'h000;
			fcalValue_reg <= regWrData;
		end else if (fcalBusy_reg) begin
			if (fcalLast) begin
				fcalBusy_reg <= 1'b0;
				applied_reg  <= fcalValue_reg;
			end else begin
				fcalCnt_reg <= fcalCnt_reg + 11'h001;
			end
		end
	end

	// ----------------------------------------
	// offset cancellation servo
	// ----------------------------------------
	rxgfc_oc_state_t ocState_reg;
	rxgfc_oc_state_t ocState_next;
	logic [7:0]      ocCnt_reg;
	logic [7:0]      ocCnt_next;
	logic [7:0]      dac_reg;
	logic [7:0]      dac_next;
	logic            fail_reg;
	logic            fail_next;
	logic            pend_reg;
	logic            pend_next;
	logic            inWindow;
	logic            ocActive;

	assign inWindow = (offsetMeas <= `RXGFC_OFS_LIMIT) && (offsetMeas >= -`RXGFC_OFS_LIMIT);
	assign ocActive = (ocState_reg != OC_IDLE);

	always_comb begin
		ocState_next = ocState_reg;
		ocCnt_next   = ocCnt_reg;
		dac_next     = dac_reg;
		fail_next    = fail_reg;
		pend_next    = pend_reg || offsetCalReq;
		case (ocState_reg)
			OC_IDLE: begin
				if (pend_next) begin
					ocState_next = OC_SETTLE;
					pend_next    = 1'b0;
					ocCnt_next   = `RXGFC_OC_SETTLE;
					dac_next     = `RXGFC_CALDAC_MID;
					fail_next    = 1'b0;
				end
			end
			OC_SETTLE: begin
				if (ocCnt_reg == 8'h00) ocState_next = OC_CHECK;
				else ocCnt_next = ocCnt_reg - 8'h01;
			end
			OC_CHECK: begin
				ocCnt_next = `RXGFC_OC_SETTLE;
				if (inWindow) begin
					ocState_next = OC_IDLE;
				end else if (offsetMeas > 12'sh000) begin
					if (dac_reg == 8'h00) begin
						ocState_next = OC_IDLE;
						fail_next    = 1'b1;
					end else begin
						ocState_next = OC_SETTLE;
						dac_next     = dac_reg - 8'h01;
					end
				end else begin
					if (dac_reg == 8'hff) begin
						ocState_next = OC_IDLE;
						fail_next    = 1'b1;
					end else begin
						ocState_next = OC_SETTLE;
						dac_next     = dac_reg + 8'h01;
					end
				end
			end
			default: begin
				ocState_next = OC_IDLE;
			end
		endcase
	end

	// pending set at reset gives the automatic power-up run
	always_ff @(posedge clk_sys or negedge rstnSys) begin
		if (!rstnSys) begin
			ocState_reg <= OC_IDLE;
			ocCnt_reg   <= 8'h00;
			dac_reg     <= `RXGFC_CALDAC_MID;
			fail_reg    <= 1'b0;
			pend_reg    <= 1'b1;
		end else begin
			ocState_reg <= ocState_next;
			ocCnt_reg   <= ocCnt_next;
			dac_reg     <= dac_next;
			fail_reg    <= fail_next;
			pend_reg    <= pend_next;
		end
	end

	// ----------------------------------------
	// stage outputs
	// ----------------------------------------
	rxgfc_stage_t c1_reg;
	rxgfc_stage_t c2_reg;
	rxgfc_stage_t f_reg;
	logic         short_reg;
	logic         busyOut_reg;

	always_ff @(posedge clk_sys or negedge rstnSys) begin
		if (!rstnSys) begin
			c1_reg      <= 3'h0;
			c2_reg      <= 3'h0;
			f_reg       <= 3'h0;
			short_reg   <= 1'b0;
			busyOut_reg <= 1'b0;
		end else begin
			// highest gain during calibration, where the servo sees offset best
			c1_reg      <= ocActive ? 3'(`RXGFC_STG1_MAX) : lutC1;
			c2_reg      <= ocActive ? 3'(`RXGFC_COARSE_MAX - `RXGFC_STG1_MAX) : lutC2;
			f_reg       <= ocActive ? `RXGFC_FINE_MAX : lutF;
			short_reg   <= ocActive;
			busyOut_reg <= ocActive;
		end
	end

	assign regRdData     = rdData_reg;
	assign coarseStage1  = c1_reg;
	assign coarseStage2  = c2_reg;
	assign fineStage     = f_reg;
	assign inputShort    = short_reg;
	assign calDacCode    = dac_reg;
	assign offsetCalBusy = busyOut_reg;
	assign offsetCalFail = fail_reg;
	assign filterEnable  = fctrl_reg[`RXGFC_FCTRL_EN_BIT];
	assign cutoffApplied = applied_reg;
	assign filterCalBusy = fcalBusy_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic [6:0] totalIdx;
	assign totalIdx = 7'(c1_reg) * 7'h06 + 7'(c2_reg) * 7'h06 + 7'(f_reg);

	property p_gain6;
		@(posedge clk_sys) disable iff (!rstnSys)
		(!ocActive && !modeSync_reg) |=> (totalIdx == 7'(rxgfc_gain_index($past(gainSync_reg), 1'b0)));
	endproperty
	a_gain6: assert property (p_gain6) else $error("six-bit gain mapping wrong");

	property p_gain3;
		@(posedge clk_sys) disable iff (!rstnSys)
		(!ocActive && modeSync_reg) |=> (totalIdx[2:0] == 3'h0) && (totalIdx <= 7'h30);
	endproperty
	a_gain3: assert property (p_gain3) else $error("three-bit gain not on 8 dB grid");

	property p_coarse;
		@(posedge clk_sys) disable iff (!rstnSys)
		(c1_reg <= 3'h4) && (c2_reg <= 3'h5);
	endproperty
	a_coarse: assert property (p_coarse) else $error("coarse stage out of range");

	property p_fine;
		@(posedge clk_sys) disable iff (!rstnSys)
		(!ocActive && (gainSync_reg < 6'h3c) && !modeSync_reg) |=> (f_reg <= 3'h5);
	endproperty
	a_fine: assert property (p_fine) else $error("fine stage used beyond need");

	property p_powerup;
		@(posedge clk_sys) disable iff (!rstnSys)
		$rose(rstnSys) |-> ##[0:3] ocActive;
	endproperty
	a_powerup: assert property (p_powerup) else $error("no offset run after reset");

	property p_force;
		@(posedge clk_sys) disable iff (!rstnSys)
		ocActive |=> inputShort && (coarseStage1 == 3'h4) && (coarseStage2 == 3'h5) && (fineStage == 3'h6);
	endproperty
	a_force: assert property (p_force) else $error("calibration not forcing high gain");

	property p_servo;
		@(posedge clk_sys) disable iff (!rstnSys)
		(ocState_reg == OC_CHECK && inWindow) |=> !ocActive && !offsetCalFail && $stable(calDacCode);
	endproperty
	a_servo: assert property (p_servo) else $error("servo did not stop in window");

	property p_fstart;
		@(posedge clk_sys) disable iff (!rstnSys)
		tgtWr |=> filterCalBusy && (fcalCnt_reg == 11'h000) && (fcalValue_reg == $past(regWrData));
	endproperty
	a_fstart: assert property (p_fstart) else $error("target write did not restart calibration");

	property p_fend;
		@(posedge clk_sys) disable iff (!rstnSys)
		(filterCalBusy && fcalLast && !tgtWr) |=> !filterCalBusy && (cutoffApplied == $past(fcalValue_reg));
	endproperty
	a_fend: assert property (p_fend) else $error("filter calibration end wrong");

	property p_fbound;
		@(posedge clk_sys) disable iff (!rstnSys)
		filterCalBusy |-> (fcalCnt_reg < 11'h7cf);
	endproperty
	a_fbound: assert property (p_fbound) else $error("filter calibration too long");

	property p_fctrl;
		@(posedge clk_sys) disable iff (!rstnSys)
		ctrlWr |=> (filterEnable == $past(regWrData[0]));
	endproperty
	a_fctrl: assert property (p_fctrl) else $error("filter enable not following write");

	property p_target;
		@(posedge clk_sys) disable iff (!rstnSys)
		(tgtWr ##1 !tgtWr ##1 (regRdEn && regAddr == 8'h08 && !regWrEn)) |=> (regRdData == $past(regWrData, 3));
	endproperty
	a_target: assert property (p_target) else $error("target readback wrong");

	c_restart: cover property (@(posedge clk_sys) disable iff (!rstnSys) filterCalBusy && tgtWr);
	c_fdone:   cover property (@(posedge clk_sys) disable iff (!rstnSys) $fell(filterCalBusy));
	c_ocfail:  cover property (@(posedge clk_sys) disable iff (!rstnSys) $rose(offsetCalFail));
	c_ocreq:   cover property (@(posedge clk_sys) disable iff (!rstnSys) !ocActive && offsetCalReq);

endmodule : rxgfc_top

/* dv/rxgfc_amp_model.sv */
`timescale 1ns/1ns

module rxgfc_amp_model (
	// clock and probes
	input  wire logic               clk_sys,
	input  wire logic [7:0]         calDacCode,
	input  wire logic               inputShort,
	input  wire logic               stuck,
	// offset seen by the converter
	output logic signed [11:0]      offsetMeas
);
	localparam logic [7:0] TRIM_CODE = 8'h78;
	logic signed [11:0] noisePat_reg = 12'sh5a5;

	always_ff @(posedge clk_sys) begin
		noisePat_reg <= ~noisePat_reg;
	end

	// unshorted input gives a moving value, so a servo that looks early sees junk
	assign offsetMeas = !inputShort ? noisePat_reg : stuck ? 12'sh400 :
		($signed({4'h0, calDacCode}) - $signed({4'h0, TRIM_CODE})) * 12'sh008;
endmodule : rxgfc_amp_model

/* dv/rxgfc_tb_top.sv */
`timescale 1ns/1ns

module rxgfc_tb_top
	import rxgfc_pkg::*;
;
	logic clk_sys, rstn, regWrEn, regRdEn, gainMode3, offsetCalReq, stuck;
	logic [7:0] regAddr, regWrData, regRdData, calDacCode, cutoffApplied, t;
	logic [5:0] gainPins;
	logic signed [11:0] offsetMeas;
	rxgfc_stage_t coarseStage1, coarseStage2, fineStage;
	logic inputShort, offsetCalBusy, offsetCalFail, filterEnable, filterCalBusy;
	logic [31:0] lfsr = 32'h28a7;
	logic [7:0] rdQ[$], calQ[$];
	int fails = 0, num_checks = 0, n, k, idx, c1;

	rxgfc_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .gainPins(gainPins),
		.gainMode3(gainMode3), .offsetCalReq(offsetCalReq), .offsetMeas(offsetMeas),
		.coarseStage1(coarseStage1), .coarseStage2(coarseStage2), .fineStage(fineStage),
		.inputShort(inputShort), .calDacCode(calDacCode), .offsetCalBusy(offsetCalBusy),
		.offsetCalFail(offsetCalFail), .filterEnable(filterEnable), .cutoffApplied(cutoffApplied),
		.filterCalBusy(filterCalBusy));

	rxgfc_amp_model i_amp (.clk_sys(clk_sys), .calDacCode(calDacCode), .inputShort(inputShort),
		.stuck(stuck), .offsetMeas(offsetMeas));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		regWrEn   = 1'b1;
		regAddr   = a;
		regWrData = d;
		@(negedge clk_sys);
		regWrEn   = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		regRdEn = 1'b1;
		regAddr = a;
		rdQ.push_back(e);
		@(negedge clk_sys);
		regRdEn = 1'b0;
	endtask : rd

	// wait for a busy flag to drop, counting negedges
	task automatic waitLow(input bit ofs, input int lim);
		for (n = 0; n < lim && (ofs ? offsetCalBusy : filterCalBusy) !== 1'b0; n++) begin
			@(negedge clk_sys);
		end
		if (n >= lim) begin
			fails++;
			end_sim();
		end
	endtask : waitLow

	task automatic reqOffset();
		@(negedge clk_sys);
		offsetCalReq = 1'b1;
		@(negedge clk_sys);
		offsetCalReq = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask : reqOffset

	// ----------------------------------------
	// result monitors
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (regRdEn === 1'b1) begin
			#1;
			if (rdQ.size() == 0) fails++;
			else chk(regRdData, rdQ.pop_front());
		end
	end

	// the drop into power-up reset is not a calibration result
	always @(negedge filterCalBusy) if (rstn === 1'b1) begin
		#1;
		if (calQ.size() == 0) fails++;
		else chk(cutoffApplied, calQ.pop_front());
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rstn, regWrEn, regRdEn, gainMode3, offsetCalReq, stuck} = 6'h00;
		{regAddr, regWrData, gainPins} = 22'h000000;
		repeat (6) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk(offsetCalBusy, 1'b1);
		chk({inputShort, coarseStage1, coarseStage2, fineStage}, {1'b1, 9'h12e});
		waitLow(1'b1, 6000);
		chk({offsetCalFail, calDacCode}, 9'h07c);
		rd(8'h07, 8'h01);
		rd(8'h08, 8'h80);
		rd(8'h33, 8'h00);
		chk(filterEnable, 1'b1);
		wr(8'h07, 8'h00);
		chk(filterEnable, 1'b0);
		wr(8'h33, 8'hff);
		rd(8'h07, 8'h00);
		wr(8'h07, 8'h01);
		chk(filterEnable, 1'b1);
		lfsr = lfsr_next(lfsr);
		t = lfsr[7:0];
		for (k = 0; k < 2; k++) begin
			calQ.push_back(t);
			wr(8'h08, t);
			waitLow(1'b0, 3000);
			chk(n, 16'h07cf);
		end
		rd(8'h08, t);
		wr(8'h08, ~t);
		rd(8'h08, ~t);
		repeat (500) @(negedge clk_sys);
		calQ.push_back(t ^ 8'h5a);
		wr(8'h08, t ^ 8'h5a);
		chk(cutoffApplied, t);
		waitLow(1'b0, 3000);
		chk(n, 16'h07cf);
		for (int i = 0; i < 72; i++) begin
			lfsr = lfsr_next(lfsr);
			@(negedge clk_sys);
			gainMode3 = (i >= 64);
			gainPins  = (i >= 64) ? {lfsr[5:3], 3'(i)} : 6'(i);
			idx = gainMode3 ? ((gainPins[2:0] > 6) ? 6 : gainPins[2:0]) * 8 : ((gainPins > 60) ? 60 : gainPins);
			k   = (idx / 6 > 9) ? 9 : idx / 6;
			c1  = (k > 4) ? 4 : k;
			repeat (4) @(negedge clk_sys);
			chk({coarseStage1, coarseStage2, fineStage}, {3'(c1), 3'(k - c1), 3'(idx - 6 * k)});
		end
		stuck = 1'b1;
		reqOffset();
		chk({offsetCalBusy, coarseStage1, coarseStage2, fineStage}, {1'b1, 9'h12e});
		waitLow(1'b1, 6000);
		chk({offsetCalFail, calDacCode}, 9'h100);
		stuck = 1'b0;
		reqOffset();
		chk(offsetCalFail, 1'b0);
		waitLow(1'b1, 6000);
		chk(calDacCode, 8'h7c);
		repeat (2) @(negedge clk_sys);
		end_sim();
	end
endmodule : rxgfc_tb_top
